// ### dr_buffer_pkg.sv
package dr_buffer_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HDR = 8'h04;
    localparam logic [7:0] ADDR_SCL = 8'h08;
    localparam logic [7:0] ADDR_OFS = 8'h0c;
    localparam logic [7:0] ADDR_SET_CTRL = 8'h10;
    localparam logic [7:0] ADDR_SET_DATA = 8'h14;
    localparam logic [7:0] ADDR_ACK = 8'h18;
    localparam logic [7:0] ADDR_REC_SEL = 8'h1c;
    localparam logic [7:0] ADDR_REC_HDR = 8'h20;
    localparam logic [7:0] ADDR_REC_DATA = 8'h24;
    localparam logic [7:0] ADDR_START = 8'h28;
    localparam logic [7:0] ADDR_PAIR_BASE = 8'h40;
    localparam logic [7:0] ADDR_PAIR_END = 8'h90;
    // report layout
    localparam int PAIRS = 20;
    localparam int RING = 19;
    localparam logic [4:0] RING_LAST = 5'h12;
    localparam logic [4:0] RING_DEPTH = 5'h13;
    localparam logic [4:0] CNT_MAX = 5'h14;
    localparam int FLAG_POS = 0;
    localparam int FLAG_HEAD = 1;
    localparam int FLAG_DIST = 2;
    localparam int FLAG_DHEAD = 3;
    localparam int FLAG_ALL = 4;
    localparam int FLAG_ROLL = 5;
    localparam int FLAG_TSRC = 6;
    // init record sources
    localparam logic [2:0] SRC_CLEAR = 3'h0;
    localparam logic [2:0] SRC_HOST = 3'h1;
    localparam logic [2:0] SRC_OVERRIDE = 3'h2;
    localparam logic [2:0] SRC_DECODE = 3'h3;
    // record kinds
    localparam logic [1:0] KIND_ALMANAC = 2'h0;
    localparam logic [1:0] KIND_TIME = 2'h1;
    localparam logic [1:0] KIND_FREQ = 2'h2;
    localparam logic [1:0] KIND_LATLON = 2'h3;
    // acknowledgment codes
    localparam logic [1:0] ACK_OK = 2'h0;
    localparam logic [1:0] ACK_CONTRADICT = 2'h1;
    localparam logic [1:0] ACK_BAD_SOURCE = 2'h2;
    // almanac satellite index range
    localparam logic [5:0] SV_MIN = 6'h01;
    localparam logic [5:0] SV_MAX = 6'h20;
    // saturation of stored deltas
    localparam logic signed [23:0] SAT_HI = 24'sh007fff;
    localparam logic signed [23:0] SAT_LO = -24'sh007fff;
    localparam int SCL_FRAC = 8;
    // start-up window for moving-start detection
    localparam int START_WINDOW_MS = 200;
    localparam int CLK_KHZ = 200000;
    localparam int START_WINDOW_CYCLES = START_WINDOW_MS * CLK_KHZ;
    typedef struct packed {
        logic [2:0] src;
        logic fresh;
        logic [9:0] week;
        logic [5:0] index;
        logic [31:0] data;
    } rec_t;
endpackage : dr_buffer_pkg

// ### dr_buffer_and_init_messages.sv
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Contract
// - first query freezes report, later queries identical
// - complete-history flag only when nothing lost
// - moving-start flag on tacho pulse within 200ms
// - distance valid only if tacho calibrated at start
// - heading valid only if gyro calibrated before motion
// - time source and validity from latest status
// - entries ordered newest first, oldest last
// - up to 20 signed 16-bit distance/heading pairs
// - unrecorded entries read as zero
// - oldest interval ends at first motion second
// - newest interval runs from last second to query
// - deltas corrected with current offset and scale
// - 16-bit millisecond time tag in report
// - host-input set may be rejected, reported in ack
// - host override set always accepted; the code refuses it with an almanac index outside 1..32
// - host input over override/decode gives contradiction
// - host freshness ignored, zero after reset
// - lost battery store signals cold start
// - latlon set triggers immediate satellite reselection
// - almanac record index, source, freshness, 10-bit week
// - source zero erases record, unknown reads zero
// - runtime decode updates replace stored values
module dr_buffer_and_init_messages #(
    parameter int START_CYCLES = dr_buffer_pkg::START_WINDOW_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sec_tick,
    input wire logic i_tacho_pulse,
    input wire logic i_heartbeat,
    input wire logic i_rate_stb,
    input wire logic signed [15:0] i_rate_raw,
    input wire logic i_dpp_cal_valid,
    input wire logic i_zro_cal_valid,
    input wire logic i_status_stb,
    input wire logic i_status_pos_valid,
    input wire logic i_status_head_valid,
    input wire logic [1:0] i_status_time_src,
    input wire logic [15:0] i_time_tag,
    input wire logic i_store_intact,
    input wire logic i_decode_stb,
    input wire logic [1:0] i_decode_kind,
    input wire logic [9:0] i_decode_week,
    input wire logic [31:0] i_decode_data,
    output logic o_reselect,
    output logic o_cold_start
);
    typedef struct packed {
        logic frozen;
        logic [dr_buffer_pkg::PAIRS-1:0][31:0] pairs;
        logic [7:0] flags;
        logic [15:0] tag;
        logic [dr_buffer_pkg::RING-1:0][31:0] ring;
        logic [4:0] wp;
        logic [4:0] cnt;
        logic signed [23:0] dist_acc;
        logic signed [23:0] head_acc;
        logic motion;
        logic [31:0] win_cnt;
        logic in_window;
        logic rolling;
        logic dist_valid;
        logic head_valid;
        logic pos_v;
        logic head_v;
        logic [1:0] tsrc;
        logic [15:0] distance_per_pulse;
        logic signed [15:0] gyro_zero_rate_offset;
        logic [31:0] set_data;
        logic [1:0] ack;
        logic [1:0] sel;
        dr_buffer_pkg::rec_t [3:0] rec;
        logic started;
        logic cold;
        logic reselect;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t q, d;

    // apb strobes and set decision
    logic wr_acc, rd_setup, query_first, set_go, set_contra, set_bad;
    logic set_ok, pulse_real;
    logic [2:0] set_src;
    logic [1:0] set_kind;
    logic [2:0] old_src;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;
    assign query_first = wr_acc && i_paddr == dr_buffer_pkg::ADDR_CTRL &&
                         i_pwdata[0] && !q.frozen;
    assign set_go = wr_acc && i_paddr == dr_buffer_pkg::ADDR_SET_CTRL;
    assign set_src = i_pwdata[2:0];
    assign set_kind = i_pwdata[4:3];
    assign old_src = q.rec[set_kind].src;
    assign set_contra = set_src == dr_buffer_pkg::SRC_HOST &&
                        (old_src == dr_buffer_pkg::SRC_OVERRIDE ||
                         old_src == dr_buffer_pkg::SRC_DECODE);
    assign set_bad = set_src > dr_buffer_pkg::SRC_OVERRIDE ||
                     (set_kind == dr_buffer_pkg::KIND_ALMANAC &&
                      set_src != dr_buffer_pkg::SRC_CLEAR &&
                      (i_pwdata[21:16] < dr_buffer_pkg::SV_MIN ||
                       i_pwdata[21:16] > dr_buffer_pkg::SV_MAX));
    assign set_ok = set_go && !set_contra && !set_bad;
    assign pulse_real = i_tacho_pulse && !i_heartbeat;

    // saturate an accumulator into a 16-bit report field
    function automatic logic [15:0] sat16(input logic signed [23:0] v);
        if (v > dr_buffer_pkg::SAT_HI) begin
            sat16 = dr_buffer_pkg::SAT_HI[15:0];
        end else if (v < dr_buffer_pkg::SAT_LO) begin
            sat16 = dr_buffer_pkg::SAT_LO[15:0];
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // next-state logic
    always_comb begin
        logic signed [23:0] dist_n;
        logic signed [23:0] head_n;
        logic [5:0] idx;
        logic [4:0] pidx;
        logic [15:0] dsat;
        dist_n = 24'sh0;
        head_n = 24'sh0;
        idx = 6'h0;
        pidx = 5'h0;
        dsat = 16'h0;
        d = q;
        d.reselect = 1'b0;
        d.pslverr = 1'b0;
        // cold start caught one cycle after reset release
        if (!q.started) begin
            d.started = 1'b1;
            d.cold = !i_store_intact;
        end
        // start-up window and calibration capture
        if (q.in_window) begin
            if (q.win_cnt == 32'(START_CYCLES - 1)) begin
                d.in_window = 1'b0;
            end
            d.win_cnt = q.win_cnt + 32'h1;
            if (pulse_real) begin
                d.rolling = 1'b1;
            end
            d.dist_valid = i_dpp_cal_valid;
        end
        if (!q.motion) begin
            d.head_valid = i_zro_cal_valid;
        end
        if (pulse_real) begin
            d.motion = 1'b1;
        end
        if (i_status_stb) begin
            d.pos_v = i_status_pos_valid;
            d.head_v = i_status_head_valid;
            d.tsrc = i_status_time_src;
        end
        // corrected increments for this cycle
        dist_n = pulse_real ? 24'(q.distance_per_pulse) : 24'sh0;
        head_n = i_rate_stb ? 24'(i_rate_raw) -
                 24'(q.gyro_zero_rate_offset) : 24'sh0;
        // close an interval on each second once motion was seen
        if (i_sec_tick && q.motion && !q.frozen) begin
            dsat = sat16(q.dist_acc >>> dr_buffer_pkg::SCL_FRAC);
            d.ring[q.wp] = {sat16(q.head_acc), dsat};
            d.wp = (q.wp == dr_buffer_pkg::RING_LAST) ? 5'h0 :
                   q.wp + 5'h1;
            if (q.cnt != dr_buffer_pkg::CNT_MAX) begin
                d.cnt = q.cnt + 5'h1;
            end
            d.dist_acc = dist_n;
            d.head_acc = head_n;
        end else if (!q.frozen) begin
            d.dist_acc = q.dist_acc + dist_n;
            d.head_acc = q.head_acc + head_n;
        end
        // first query takes the whole snapshot in one cycle
        if (query_first) begin
            d.frozen = 1'b1;
            dsat = sat16(q.dist_acc >>> dr_buffer_pkg::SCL_FRAC);
            d.pairs[0] = {sat16(q.head_acc), dsat};
            for (int k = 1; k < dr_buffer_pkg::PAIRS; k++) begin
                idx = {1'b0, q.wp} - 6'(k);
                if (idx[5]) begin
                    idx = idx + {1'b0, dr_buffer_pkg::RING_DEPTH};
                end
                if (5'(k) <= q.cnt) begin
                    d.pairs[k] = q.ring[idx[4:0]];
                end else begin
                    d.pairs[k] = 32'h0;
                end
            end
            d.flags = 8'h0;
            d.flags[dr_buffer_pkg::FLAG_POS] = q.pos_v;
            d.flags[dr_buffer_pkg::FLAG_HEAD] = q.head_v;
            d.flags[dr_buffer_pkg::FLAG_DIST] = q.dist_valid;
            d.flags[dr_buffer_pkg::FLAG_DHEAD] = q.head_valid;
            d.flags[dr_buffer_pkg::FLAG_ALL] =
                q.cnt <= dr_buffer_pkg::RING_DEPTH;
            d.flags[dr_buffer_pkg::FLAG_ROLL] = q.rolling;
            d.flags[dr_buffer_pkg::FLAG_TSRC +: 2] = q.tsrc;
            d.tag = i_time_tag;
        end
        // runtime decode refreshes a record unless a host set hits it
        if (i_decode_stb && !(set_ok && set_kind == i_decode_kind)) begin
            d.rec[i_decode_kind].src = dr_buffer_pkg::SRC_DECODE;
            d.rec[i_decode_kind].fresh = 1'b1;
            d.rec[i_decode_kind].week = i_decode_week;
            d.rec[i_decode_kind].data = i_decode_data;
        end
        // register writes
        if (wr_acc) begin
            if (i_paddr == dr_buffer_pkg::ADDR_SCL) begin
                d.distance_per_pulse = i_pwdata[15:0];
            end else if (i_paddr == dr_buffer_pkg::ADDR_OFS) begin
                d.gyro_zero_rate_offset = i_pwdata[15:0];
            end else if (i_paddr == dr_buffer_pkg::ADDR_SET_DATA) begin
                d.set_data = i_pwdata;
            end else if (i_paddr == dr_buffer_pkg::ADDR_REC_SEL) begin
                d.sel = i_pwdata[1:0];
            end
        end
        // set command: erase, accept or refuse with an ack code
        if (set_go) begin
            if (set_bad) begin
                d.ack = dr_buffer_pkg::ACK_BAD_SOURCE;
            end else if (set_contra) begin
                d.ack = dr_buffer_pkg::ACK_CONTRADICT;
            end else begin
                d.ack = dr_buffer_pkg::ACK_OK;
                if (set_src == dr_buffer_pkg::SRC_CLEAR) begin
                    d.rec[set_kind] = '0;
                end else begin
                    d.rec[set_kind].src = set_src;
                    d.rec[set_kind].fresh = 1'b1;
                    d.rec[set_kind].week = i_pwdata[14:5];
                    d.rec[set_kind].index = i_pwdata[21:16];
                    d.rec[set_kind].data = q.set_data;
                    if (set_kind == dr_buffer_pkg::KIND_LATLON) begin
                        d.reselect = 1'b1;
                    end
                end
            end
        end
        // read data is prepared in the setup cycle
        if (rd_setup) begin
            d.prdata = 32'h0;
            pidx = 5'((i_paddr - dr_buffer_pkg::ADDR_PAIR_BASE) >> 2);
            if (i_paddr[1:0] != 2'h0) begin
                d.pslverr = 1'b1;
            end else if (i_paddr == dr_buffer_pkg::ADDR_CTRL) begin
                d.prdata[0] = q.frozen;
            end else if (i_paddr == dr_buffer_pkg::ADDR_HDR) begin
                d.prdata[23:0] = {q.tag, q.flags};
            end else if (i_paddr == dr_buffer_pkg::ADDR_SCL) begin
                d.prdata[15:0] = q.distance_per_pulse;
            end else if (i_paddr == dr_buffer_pkg::ADDR_OFS) begin
                d.prdata[15:0] = q.gyro_zero_rate_offset;
            end else if (i_paddr == dr_buffer_pkg::ADDR_SET_CTRL) begin
                d.prdata = 32'h0;
            end else if (i_paddr == dr_buffer_pkg::ADDR_SET_DATA) begin
                d.prdata = q.set_data;
            end else if (i_paddr == dr_buffer_pkg::ADDR_ACK) begin
                d.prdata[1:0] = q.ack;
            end else if (i_paddr == dr_buffer_pkg::ADDR_REC_SEL) begin
                d.prdata[1:0] = q.sel;
            end else if (i_paddr == dr_buffer_pkg::ADDR_REC_HDR) begin
                d.prdata[2:0] = q.rec[q.sel].src;
                d.prdata[3] = q.rec[q.sel].fresh;
                d.prdata[7:6] = q.rec[q.sel].week[9:8];
                d.prdata[15:8] = q.rec[q.sel].week[7:0];
                d.prdata[21:16] = q.rec[q.sel].index;
            end else if (i_paddr == dr_buffer_pkg::ADDR_REC_DATA) begin
                d.prdata = q.rec[q.sel].data;
            end else if (i_paddr == dr_buffer_pkg::ADDR_START) begin
                d.prdata[0] = q.cold;
            end else if (i_paddr >= dr_buffer_pkg::ADDR_PAIR_BASE &&
                         i_paddr < dr_buffer_pkg::ADDR_PAIR_END) begin
                d.prdata = q.pairs[pidx];
            end else begin
                d.pslverr = 1'b1;
            end
        end else if (i_psel) begin
            d.pslverr = q.pslverr;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
            q.in_window <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign o_prdata = q.prdata;
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = q.pslverr && i_psel && i_penable;
    assign o_reselect = q.reselect;
    assign o_cold_start = q.cold;

    // checks
    property p_freeze_hold;
        @(posedge i_clk) disable iff (i_reset)
        q.frozen |=> $stable(q.pairs) && $stable(q.tag) && q.frozen;
    endproperty
    a_freeze_hold: assert property (p_freeze_hold)
        else $error("frozen report changed");
    property p_query_freezes;
        @(posedge i_clk) disable iff (i_reset)
        query_first |=> q.frozen && q.tag == $past(i_time_tag);
    endproperty
    a_query_freezes: assert property (p_query_freezes)
        else $error("query did not freeze report");
    property p_all_data;
        @(posedge i_clk) disable iff (i_reset)
        query_first |=> q.flags[dr_buffer_pkg::FLAG_ALL] ==
                        ($past(q.cnt) < dr_buffer_pkg::CNT_MAX);
    endproperty
    a_all_data: assert property (p_all_data)
        else $error("complete flag wrong");
    property p_rolling;
        @(posedge i_clk) disable iff (i_reset)
        $rose(q.rolling) |-> $past(q.in_window) && $past(pulse_real);
    endproperty
    a_rolling: assert property (p_rolling)
        else $error("moving-start flag outside window");
    property p_zero_fill;
        @(posedge i_clk) disable iff (i_reset)
        query_first && q.cnt < dr_buffer_pkg::RING_DEPTH
        |=> q.pairs[dr_buffer_pkg::PAIRS-1] == 32'h0;
    endproperty
    a_zero_fill: assert property (p_zero_fill)
        else $error("unrecorded entry not zero");
    property p_contra;
        @(posedge i_clk) disable iff (i_reset)
        set_go && set_contra && !set_bad
        |=> q.ack == dr_buffer_pkg::ACK_CONTRADICT &&
            ($past(i_decode_stb) || $stable(q.rec));
    endproperty
    a_contra: assert property (p_contra)
        else $error("contradiction not reported");
    property p_erase;
        @(posedge i_clk) disable iff (i_reset)
        set_ok && set_src == dr_buffer_pkg::SRC_CLEAR
        |=> q.rec[$past(set_kind)] == '0;
    endproperty
    a_erase: assert property (p_erase)
        else $error("erase left data");
    property p_reselect;
        @(posedge i_clk) disable iff (i_reset)
        o_reselect |-> $past(set_ok) &&
                       $past(set_kind) == dr_buffer_pkg::KIND_LATLON;
    endproperty
    a_reselect: assert property (p_reselect)
        else $error("reselect without latlon set");
    property p_dist_valid;
        @(posedge i_clk) disable iff (i_reset)
        query_first && !q.dist_valid
        |=> !q.flags[dr_buffer_pkg::FLAG_DIST] ##1 q.frozen;
    endproperty
    a_dist_valid: assert property (p_dist_valid)
        else $error("distance valid without calibration");
endmodule : dr_buffer_and_init_messages

// ### dr_host_model.sv
`timescale 1ns/1ps
// host side of the register bus, one transfer at a time
module dr_host_model (
    input wire logic i_clk,
    input wire logic i_pready,
    input wire logic i_pslverr,
    input wire logic [31:0] i_prdata,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    // idle bus at time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // setup, then access held until pready; wait is bounded
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd,
            output logic err, output bit ok);
        ok = 1'b0;
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge i_clk);
            if (i_pready === 1'b1) begin
                ok = 1'b1;
                rd = i_prdata;
                err = i_pslverr;
            end
        end
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata <= ~d; // released data no longer valid
    endtask : xfer
endmodule : dr_host_model

// ### dr_buffer_and_init_messages_bench.sv
`timescale 1ns/1ps
module dr_buffer_and_init_messages_bench;
    logic i_clk, i_reset, i_sec_tick, i_tacho_pulse, i_heartbeat;
    logic i_rate_stb, i_dpp_cal_valid, i_zro_cal_valid, i_status_stb;
    logic i_status_pos_valid, i_status_head_valid, i_store_intact;
    logic i_decode_stb, psel, penable, pwrite, o_pready, o_pslverr, err;
    logic o_reselect, o_cold_start;
    logic signed [15:0] i_rate_raw;
    logic [1:0] i_status_time_src, i_decode_kind;
    logic [15:0] i_time_tag;
    logic [9:0] i_decode_week;
    logic [7:0] paddr;
    logic [31:0] i_decode_data, o_prdata, pwdata, rd, e_hdr;
    logic [31:0] e_pair[20];
    int fail_count, samples_checked, resel_n, exp_resel;
    int seed = 32'h9c001bac;
    // reference model state
    int m_src[4], m_fr[4], m_wk[4], m_ix[4], m_dat[4];
    int cur_d, cur_h, scl, ofs, q_d[$], q_h[$];
    bit moved;

    dr_buffer_and_init_messages #(
        .START_CYCLES(50)
    ) u_dr_buffer_and_init_messages (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_sec_tick(i_sec_tick),
        .i_tacho_pulse(i_tacho_pulse), .i_heartbeat(i_heartbeat),
        .i_rate_stb(i_rate_stb), .i_rate_raw(i_rate_raw),
        .i_dpp_cal_valid(i_dpp_cal_valid),
        .i_zro_cal_valid(i_zro_cal_valid), .i_status_stb(i_status_stb),
        .i_status_pos_valid(i_status_pos_valid),
        .i_status_head_valid(i_status_head_valid),
        .i_status_time_src(i_status_time_src), .i_time_tag(i_time_tag),
        .i_store_intact(i_store_intact), .i_decode_stb(i_decode_stb),
        .i_decode_kind(i_decode_kind), .i_decode_week(i_decode_week),
        .i_decode_data(i_decode_data), .o_reselect(o_reselect),
        .o_cold_start(o_cold_start)
    );

    dr_host_model u_dr_host_model (
        .i_clk(i_clk), .i_pready(o_pready), .i_pslverr(o_pslverr),
        .i_prdata(o_prdata), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
    );

    // 200 mhz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // count reselect pulses
    always @(posedge i_clk) begin
        if (o_reselect === 1'b1) resel_n <= resel_n + 1;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        bit ok;
        u_dr_host_model.xfer(w, a, d, rd, err, ok);
        if (!ok) begin
            fail_count++;
            stop_test();
        end
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask : rdc

    // two-cycle reset, model emptied
    task automatic do_reset(input logic intact);
        i_store_intact <= intact;
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        foreach (m_src[k]) begin
            m_src[k] = 0;
            m_fr[k] = 0;
            m_wk[k] = 0;
            m_ix[k] = 0;
            m_dat[k] = 0;
        end
        cur_d = 0;
        cur_h = 0;
        moved = 0;
        q_d.delete();
        q_h.delete();
    endtask : do_reset

    // one sensor cycle, mirrored in the interval model
    task automatic cyc(input bit t, p, h, s, input int r);
        @(posedge i_clk);
        i_sec_tick <= t;
        i_tacho_pulse <= p;
        i_heartbeat <= h;
        i_rate_stb <= s;
        i_rate_raw <= 16'(r);
        if (t && moved) begin
            q_d.push_front(cur_d);
            q_h.push_front(cur_h);
            cur_d = 0;
            cur_h = 0;
        end
        if (p && !h) begin
            moved = 1;
            cur_d += scl / 256;
        end
        if (s) cur_h += r - ofs;
    endtask : cyc

    task automatic ivl(input int n);
        repeat (n) begin
            repeat (6) cyc(0, $random(seed), 0, $random(seed),
                $random(seed) % 100);
            cyc(1, 0, 0, 0, 0);
        end
        cyc(0, 0, 0, 0, 0);
    endtask : ivl

    task automatic recchk(input int k);
        apb(1'b1, dr_buffer_pkg::ADDR_REC_SEL, 32'(k));
        rdc("rec_hdr", dr_buffer_pkg::ADDR_REC_HDR, {10'h0, 6'(m_ix[k]),
            8'(m_wk[k]), 2'(m_wk[k] >> 8), 2'h0, 1'(m_fr[k]),
            3'(m_src[k])});
        rdc("rec_data", dr_buffer_pkg::ADDR_REC_DATA, m_dat[k]);
        chk("reselect", resel_n, exp_resel);
    endtask : recchk

    task automatic iset(input int k, s, w, x, d);
        int a;
        apb(1'b1, dr_buffer_pkg::ADDR_SET_DATA, d);
        apb(1'b1, dr_buffer_pkg::ADDR_SET_CTRL,
            {10'h0, 6'(x), 1'b0, 10'(w), 2'(k), 3'(s)});
        a = (s > 2 || (k == 0 && (x < 1 || x > 32))) ? 2 :
            (s == 1 && m_src[k] > 1) ? 1 : 0;
        if (a == 0) begin
            m_src[k] = s;
            m_fr[k] = (s != 0);
            m_wk[k] = s ? w : 0;
            m_ix[k] = s ? x : 0;
            m_dat[k] = s ? d : 0;
            exp_resel += (k == 3 && s != 0);
        end
        rdc("ack", dr_buffer_pkg::ADDR_ACK, a);
        recchk(k);
    endtask : iset

    // main sequence
    initial begin
        i_reset = 1'b1;
        {i_sec_tick, i_tacho_pulse, i_heartbeat, i_rate_stb, i_rate_raw,
            i_dpp_cal_valid, i_zro_cal_valid, i_status_stb,
            i_status_pos_valid, i_status_head_valid, i_status_time_src,
            i_time_tag, i_store_intact, i_decode_stb, i_decode_kind,
            i_decode_week, i_decode_data} = '0;
        for (int ps = 0; ps < 2; ps++) begin
            i_dpp_cal_valid <= (ps == 0);
            i_zro_cal_valid <= 1'(ps);
            do_reset(1'(ps));
            apb(1'b1, dr_buffer_pkg::ADDR_SCL, 32'h100);
            apb(1'b1, dr_buffer_pkg::ADDR_OFS, 32'h0);
            scl = 256;
            ofs = 0;
            if (ps == 0) begin
                cyc(0, 1, 0, 0, 0);
            end else begin
                cyc(0, 1, 1, 0, 0);
                repeat (60) cyc(0, 0, 0, 0, 0);
            end
            ivl(2 + 20 * ps);
            apb(1'b1, dr_buffer_pkg::ADDR_SCL, 32'h200);
            apb(1'b1, dr_buffer_pkg::ADDR_OFS, 32'h5);
            scl = 512;
            ofs = 5;
            ivl(3);
            repeat (4) cyc(0, $random(seed), 0, 1, $random(seed) % 100);
            cyc(0, 0, 0, 0, 0);
            repeat (2) begin
                @(posedge i_clk);
                i_status_stb <= 1'b1;
                {i_status_pos_valid, i_status_head_valid,
                    i_status_time_src} <= 4'($random(seed));
            end
            @(posedge i_clk);
            i_status_stb <= 1'b0;
            i_time_tag <= 16'($random(seed));
            apb(1'b1, dr_buffer_pkg::ADDR_CTRL, 32'h1);
            e_hdr = {8'h0, i_time_tag, i_status_time_src, 1'(ps == 0),
                1'(q_d.size() < 20), 1'(ps), 1'(ps == 0),
                i_status_head_valid, i_status_pos_valid};
            for (int k = 0; k < 20; k++) begin
                e_pair[k] = k == 0 ? {cur_h[15:0], cur_d[15:0]} :
                    k <= q_d.size() ? {q_h[k-1][15:0], q_d[k-1][15:0]} :
                    32'h0;
            end
            // activity after the freeze must not show
            ivl(1);
            i_time_tag <= ~i_time_tag;
            apb(1'b1, dr_buffer_pkg::ADDR_CTRL, 32'h1);
            rdc("ctrl", dr_buffer_pkg::ADDR_CTRL, 32'h1);
            rdc("hdr", dr_buffer_pkg::ADDR_HDR, e_hdr);
            for (int k = 0; k < 20; k++) begin
                rdc("pair", 8'(dr_buffer_pkg::ADDR_PAIR_BASE + 4 * k),
                    e_pair[k]);
            end
            rdc("start", dr_buffer_pkg::ADDR_START, 32'(ps == 0));
            chk("cold", o_cold_start, 32'(ps == 0));
            rdc("unmapped", 8'h2c, 32'h0);
            chk("slverr", err, 32'h1);
            $display("dr buffer pass %0d done", ps);
        end
        // host sets in documented order: almanac, time, freq, latlon
        for (int k = 0; k < 4; k++) begin
            iset(k, 1, 100 + k, k == 0, $random(seed));
        end
        iset(0, 1, 5, 33, 7);
        iset(0, 1, 5, 0, 7);
        iset(2, 4, 5, 0, 7);
        @(posedge i_clk);
        i_decode_stb <= 1'b1;
        i_decode_kind <= 2'h1;
        i_decode_week <= 10'h2bc;
        i_decode_data <= 32'h1234abcd;
        @(posedge i_clk);
        i_decode_stb <= 1'b0;
        m_src[1] = 3;
        m_fr[1] = 1;
        m_wk[1] = 10'h2bc;
        m_dat[1] = 32'h1234abcd;
        recchk(1);
        iset(1, 1, 9, 0, 3);
        iset(1, 2, 9, 0, 3);
        iset(1, 1, 9, 0, 4);
        iset(0, 2, 1023, 32, 8);
        iset(1, 0, 0, 0, 0);
        iset(3, 2, 12, 0, 9);
        do_reset(1'b1);
        for (int k = 0; k < 4; k++) begin
            recchk(k);
        end
        $display("init records done");
        stop_test();
    end
endmodule : dr_buffer_and_init_messages_bench
